/* core/vplr_pkg.sv */
/*
  Package for the video loop lock controller: register offsets, status bit
  positions, timing counts and the carrier structs shared by the design files.
  Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
*/
package vplr_pkg;

  // ==========================================================================
  // Register map (byte addresses, word aligned).
  localparam logic [3:0] VPLR_OFS_TRIGGER = 4'h0;
  localparam logic [3:0] VPLR_OFS_STATUS  = 4'h4;
  localparam logic [3:0] VPLR_OFS_CONFIG  = 4'h8;
  localparam logic [3:0] VPLR_OFS_ATTEMPT = 4'hc;

  // ==========================================================================
  // Status word bit positions, and the trigger bit.
  localparam int VPLR_ST_RESET_DONE = 0;
  localparam int VPLR_ST_LOCK       = 1;
  localparam int VPLR_ST_RECAL      = 2;
  localparam int VPLR_ST_REF_LOST   = 3;
  localparam int VPLR_ST_JITTER     = 5;
  localparam int VPLR_ST_BYPASS     = 6;
  localparam int VPLR_TRIG_BIT      = 0;

  // ==========================================================================
  // Timing: settle time of the loop, and controller reset time, in cycles; then register reset values.
  localparam int VPLR_REF_NS        = 10;
  localparam int VPLR_LOCK_TIME_NS  = 2000;
  localparam logic [11:0] VPLR_LOCK_CYCLES = 12'(VPLR_LOCK_TIME_NS / VPLR_REF_NS);
  localparam logic [11:0] VPLR_CTRL_RESET_CYCLES = 12'h010;
  localparam logic [4:0]  VPLR_FAIL_FIRST = 5'h01;
  localparam logic [31:0] VPLR_CONFIG_RESET = 32'h0000_0000;

  // ==========================================================================
  // Loop state machine.
  typedef enum logic [2:0] {
    VPLR_S_CTRL_RESET,
    VPLR_S_BYPASS,
    VPLR_S_LOCKING,
    VPLR_S_LOCKED,
    VPLR_S_FAILED
  } vplr_state_t;

  // Status bits carried from the loop core to the register file.
  typedef struct packed {
    logic bypass;
    logic high_jitter_flag;
    logic reference_lost_flag;
    logic recalibration_needed;
    logic lock;
    logic controller_reset_complete;
  } vplr_status_t;

  // Full state of the loop core.
  typedef struct packed {
    vplr_state_t  state;
    logic [11:0]  count;
    logic [4:0]   attempts;
    logic         ref_seen_lost;
  } vplr_core_t;

endpackage

/* core/vplr_loop_core.sv */
/*
  Loop core: models the lock sequence of the video loop, including the
  failed first attempt after initialization and the later successful retry.
  Assumes start pulses come from the register file in the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module vplr_loop_core (
  input  wire logic                  clock_in,
  input  wire logic                  rstn_in,
  input  wire logic                  start_in,
  input  wire logic                  reference_ok_in,
  input  wire logic [4:0]            fail_first_in,
  output vplr_pkg::vplr_status_t     status_out,
  output logic [4:0]                 attempts_out
);
  import vplr_pkg::*;

  vplr_core_t r;
  vplr_core_t next_r;

  // ==========================================================================
  // Next state: reset, bypass, locking attempt, and its outcome.
  always_comb begin
    next_r = r;
    if (!reference_ok_in) begin
      next_r.ref_seen_lost = 1'b1;
    end
    unique case (r.state)
      VPLR_S_CTRL_RESET: begin
        next_r.count = r.count + 12'h001;
        if (r.count == VPLR_CTRL_RESET_CYCLES) begin
          next_r.state = VPLR_S_BYPASS;
        end
      end
      VPLR_S_LOCKING: begin
        next_r.count = r.count + 12'h001;
        if (!reference_ok_in) begin
          next_r.state = VPLR_S_FAILED;
        end else if (r.count == VPLR_LOCK_CYCLES) begin
          // Early attempts may fail; a later retry locks unless fail_first_in is 31, where attempts saturate.
          next_r.state = (r.attempts <= fail_first_in) ? VPLR_S_FAILED : VPLR_S_LOCKED;
        end
      end
      default: begin
      end
    endcase
    // A trigger always restarts the lock sequence once reset is done.
    if (start_in && r.state != VPLR_S_CTRL_RESET) begin
      next_r.state = VPLR_S_LOCKING;
      next_r.count = 12'h000;
      next_r.ref_seen_lost = !reference_ok_in;
      if (r.attempts != 5'h1f) begin
        next_r.attempts = r.attempts + 5'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '{state: VPLR_S_CTRL_RESET, count: 12'h000, attempts: 5'h00, ref_seen_lost: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Status decode from the state.
  always_comb begin
    status_out.controller_reset_complete = (r.state != VPLR_S_CTRL_RESET);
    status_out.lock                      = (r.state == VPLR_S_LOCKED);
    status_out.bypass                    = (r.state == VPLR_S_BYPASS) ||
                                           (r.state == VPLR_S_CTRL_RESET);
    status_out.high_jitter_flag          = (r.state == VPLR_S_FAILED) && !r.ref_seen_lost;
    status_out.reference_lost_flag       = r.ref_seen_lost && (r.state != VPLR_S_LOCKED);
    status_out.recalibration_needed      = (r.state == VPLR_S_FAILED);
  end
  assign attempts_out = r.attempts;

  // Locked state never shows an error indication.
  a_locked_clean: assert property (@(posedge clock_in) disable iff (!rstn_in)
    status_out.lock |-> !status_out.bypass && !status_out.high_jitter_flag &&
    !status_out.reference_lost_flag && !status_out.recalibration_needed)
    else $error("Locked with an error indication.");

  // Lock is never shown before the controller reset has completed.
  a_reset_before_lock: assert property (@(posedge clock_in) disable iff (!rstn_in)
    status_out.lock |-> status_out.controller_reset_complete)
    else $error("Lock shown before controller reset completed.");

  // A retry past the failing attempts, with a good reference, ends locked.
  a_retry_locks: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (r.state == VPLR_S_LOCKING && r.count == VPLR_LOCK_CYCLES && reference_ok_in &&
     r.attempts > fail_first_in && !start_in) |=> status_out.lock)
    else $error("Retry attempt did not lock.");

endmodule
`default_nettype wire

/* core/vplr_top.sv */
/*
  Video loop lock controller top: Avalon-MM register slave with trigger,
  status, configuration and attempt-count registers, around the loop core.
  Assumes one 100 MHz clock and a master that holds requests until waitrequest
  is low.
*/
`timescale 1ns/100ps
`default_nettype none
module vplr_top (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic        reference_ok_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [31:0]      loop_config_out,
  output logic             lock_out
);
  import vplr_pkg::*;

  // ==========================================================================
  // Register state in one struct.
  typedef struct packed {
    logic [31:0] rdata;
    logic        ack;
    logic        trigger;
    logic [31:0] config_word;
    logic [4:0]  fail_first;
    logic        lock;
  } vplr_regs_t;

  vplr_regs_t   r;
  vplr_regs_t   next_r;
  vplr_status_t status;
  logic [4:0]   attempts;
  logic         access;

  // Merge byte lanes of a write into a word.
  function automatic logic [31:0] vplr_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Loop core.
  vplr_loop_core u_core (
    .clock_in        (clock_in),
    .rstn_in         (rstn_in),
    .start_in        (r.trigger),
    .reference_ok_in (reference_ok_in),
    .fail_first_in   (r.fail_first),
    .status_out      (status),
    .attempts_out    (attempts)
  );

  // A request is answered one cycle after it is seen, then released.
  assign access = (avs_read_in || avs_write_in) && !r.ack;

  // ==========================================================================
  // Register file next state.
  always_comb begin
    next_r         = r;
    next_r.ack     = access;
    next_r.trigger = 1'b0;
    next_r.lock    = status.lock;
    if (access && avs_write_in) begin
      unique case (avs_address_in)
        VPLR_OFS_TRIGGER: begin
          // Setting bit 0 pulses the start of a lock sequence.
          next_r.trigger = avs_byteenable_in[0] && avs_writedata_in[VPLR_TRIG_BIT];
        end
        VPLR_OFS_CONFIG: begin
          next_r.config_word = vplr_merge(r.config_word, avs_writedata_in, avs_byteenable_in);
        end
        VPLR_OFS_ATTEMPT: begin
          if (avs_byteenable_in[0]) begin
            next_r.fail_first = avs_writedata_in[4:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (access && avs_read_in) begin
      next_r.rdata = 32'h0000_0000;
      unique case (avs_address_in)
        VPLR_OFS_TRIGGER: next_r.rdata = 32'h0000_0000;
        VPLR_OFS_STATUS: begin
          next_r.rdata[VPLR_ST_BYPASS]     = status.bypass;
          next_r.rdata[VPLR_ST_JITTER]     = status.high_jitter_flag;
          next_r.rdata[VPLR_ST_REF_LOST]   = status.reference_lost_flag;
          next_r.rdata[VPLR_ST_RECAL]      = status.recalibration_needed;
          next_r.rdata[VPLR_ST_LOCK]       = status.lock;
          next_r.rdata[VPLR_ST_RESET_DONE] = status.controller_reset_complete;
        end
        VPLR_OFS_CONFIG:  next_r.rdata = r.config_word;
        VPLR_OFS_ATTEMPT: next_r.rdata = {19'h00000, attempts, 3'h0, r.fail_first};
        default:          next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Register update.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '{rdata: 32'h0000_0000, ack: 1'b0, trigger: 1'b0, config_word: VPLR_CONFIG_RESET,
             fail_first: VPLR_FAIL_FIRST, lock: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops; waitrequest is low only in the answer cycle.
  assign avs_readdata_out    = r.rdata;
  assign avs_waitrequest_out = !r.ack;
  assign loop_config_out     = r.config_word;
  assign lock_out            = r.lock;

  // A trigger write starts a lock sequence: lock drops within three cycles.
  a_trigger_starts: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (access && avs_write_in && avs_address_in == VPLR_OFS_TRIGGER && avs_byteenable_in[0] &&
     avs_writedata_in[0] && status.controller_reset_complete) |-> ##[1:3] !status.lock)
    else $error("Trigger did not start a lock sequence.");

  // The lock output follows status bit 1 one cycle later.
  a_lock_out_follows: assert property (@(posedge clock_in) disable iff (!rstn_in)
    1'b1 |=> (lock_out == $past(status.lock)))
    else $error("Lock output does not follow the lock status.");

  // Every request is answered on the next edge.
  a_bus_answer: assert property (@(posedge clock_in) disable iff (!rstn_in)
    access |=> !avs_waitrequest_out)
    else $error("Bus request not answered in one cycle.");

endmodule
`default_nettype wire

/* dv/vplr_tb.sv */
/*
  Testbench for the video loop lock controller, with a small model of the
  expected lock outcome per attempt. Assumes vplr_pkg and vplr_top are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import vplr_pkg::*;
  logic        clock_in, rstn_in, avs_read_in, avs_write_in, reference_ok_in;
  logic        avs_waitrequest_out, lock_out;
  logic [3:0]  avs_address_in, avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, loop_config_out, rd, cfg, d;
  int          fail_count = 0, n_compared = 0, cycles = 0, attempts = 0, fail_first = 1;

  vplr_top dut (.clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .reference_ok_in(reference_ok_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .loop_config_out(loop_config_out), .lock_out(lock_out));

  // ==========================================================================
  // Clock and hang guard.
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon-MM transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_byteenable_in <= be;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  // Trigger one attempt, poll the status within the software window, judge it.
  task automatic attempt(output logic [31:0] st);
    int t0;
    bus(1'b1, VPLR_OFS_TRIGGER, 32'h1, 4'h1, rd);
    attempts++;
    t0 = cycles;
    st = 32'h0;
    while ((st & 32'h2e) === 32'h0 && cycles - t0 < 1000) bus(1'b0, VPLR_OFS_STATUS, 32'h0, 4'hf, st);
    check(32'(cycles - t0 < 1000), 32'h1);
    if (!reference_ok_in) check(st & 32'h0a, 32'h08);
    else if (attempts <= fail_first) check(st & 32'h26, 32'h24);
    else begin
      check(st & 32'h6f, 32'h03);
      check({31'h0, lock_out}, 32'h1);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(58280));
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, avs_byteenable_in} = '0;
    reference_ok_in = 1'b1;
    rstn_in = 1'b0;
    repeat (3) @(posedge clock_in);
    check({avs_waitrequest_out, lock_out}, 32'h2);
    check(avs_readdata_out | loop_config_out, 32'h0);
    rstn_in <= 1'b1;
    // Wait for the controller reset to finish; the loop sits in bypass.
    rd = 32'h0;
    for (int i = 0; i < 40 && rd[VPLR_ST_RESET_DONE] !== 1'b1; i++) bus(1'b0, VPLR_OFS_STATUS, 32'h0, 4'hf, rd);
    check(rd & 32'h6f, 32'h41);
    // Configuration written whole, then by lanes, before the first trigger.
    cfg = $urandom;
    bus(1'b1, VPLR_OFS_CONFIG, cfg, 4'hf, rd);
    d = $urandom;
    bus(1'b1, VPLR_OFS_CONFIG, d, 4'h5, rd);
    for (int i = 0; i < 4; i++) if (i % 2 == 0) cfg[8*i+:8] = d[8*i+:8];
    bus(1'b0, VPLR_OFS_CONFIG, 32'h0, 4'hf, rd);
    check(rd, cfg);
    check(loop_config_out, cfg);
    // Trigger reads back zero; an unmapped offset reads zero.
    bus(1'b0, VPLR_OFS_TRIGGER, 32'h0, 4'hf, rd);
    check(rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0, 4'hf, rd);
    check(rd, 32'h0);
    bus(1'b0, VPLR_OFS_ATTEMPT, 32'h0, 4'hf, rd);
    check(rd & 32'h1f1f, 32'h0001);
    // First attempt fails, the retry locks.
    attempt(rd);
    attempt(rd);
    // Reference lost during an attempt.
    reference_ok_in <= 1'b0;
    attempt(rd);
    reference_ok_in <= 1'b1;
    // Several failing attempts, retried at most twenty times.
    fail_first = attempts + 3;
    bus(1'b1, VPLR_OFS_ATTEMPT, 32'(fail_first), 4'h1, rd);
    for (int n = 0; n < 20 && attempts <= fail_first + 1; n++) attempt(rd);
    check(32'(rd[VPLR_ST_LOCK]), 32'h1);
    bus(1'b0, VPLR_OFS_ATTEMPT, 32'h0, 4'hf, rd);
    check(rd & 32'h1f1f, 32'((attempts << 8) | fail_first));
    check(loop_config_out, cfg);
    complete_run();
  end
endmodule
`default_nettype wire
